// ---- logic/art_cfg.svh ----
// Constants for the auto-reload timer: register addresses, fields, resets, dividers
`ifndef ART_CFG_SVH
`define ART_CFG_SVH

`define ART_ADDR_CONTROL     8'h91
`define ART_ADDR_RELOAD_LO   8'h92
`define ART_ADDR_RELOAD_HI   8'h93
`define ART_ADDR_COUNT_LO    8'h94
`define ART_ADDR_COUNT_HI    8'h95

`define ART_BIT_OVERFLOW     7
`define ART_BIT_RUN          2
`define ART_BIT_DIV_SEL      1
`define ART_BIT_EXT_SEL      0
`define ART_CTRL_WMASK       8'h87
`define ART_RESET_BYTE       8'h00

`define ART_SYSTEM_CLOCK_DIV       12
`define ART_EXTCLK_DIV       8
`define ART_DIV_W            4

`endif

// ---- logic/art_pkg.sv ----
// Types for the auto-reload timer
package art_pkg;
   typedef logic [7:0]  art_byte_t;
   typedef logic [15:0] art_count_t;
   typedef enum logic [1:0] {
      ART_SRC_SYS_DIV12,
      ART_SRC_SYS_DIV1,
      ART_SRC_EXT_DIV8
   } art_src_t;
endpackage

// ---- logic/art_tick_gen.sv ----
// Timer tick enable generator: prescalers and source selection
`timescale 1ns/1ps
`include "art_cfg.svh"
module art_tick_gen (
   input  wire logic              clk_sys_in,
   input  wire logic              rst_n_in,
   input  wire art_pkg::art_src_t src_in,
   input  wire logic              ext_osc_in,
   output logic                   tick_out
);
   logic [`ART_DIV_W-1:0] sys_cnt_q;
   logic [`ART_DIV_W-1:0] sys_cnt_d;
   logic [`ART_DIV_W-1:0] ext_cnt_q;
   logic [`ART_DIV_W-1:0] ext_cnt_d;
   logic                  ext_s1_q;
   logic                  ext_s2_q;
   logic                  ext_s3_q;
   wire                   sys_wrap;
   wire                   ext_rise;
   wire                   ext_wrap;

   ////////////////////////////////////////////////////////////////////////////////
   // System clock divide by 12
   assign sys_wrap  = (sys_cnt_q == `ART_DIV_W'(`ART_SYSTEM_CLOCK_DIV - 1));
   assign sys_cnt_d = sys_wrap ? '0 : sys_cnt_q + `ART_DIV_W'(1);
   // Edge taken from second and third stages only, never the first
   assign ext_rise  = ext_s2_q & ~ext_s3_q;
   assign ext_wrap  = ext_rise && (ext_cnt_q == `ART_DIV_W'(`ART_EXTCLK_DIV - 1));
   assign ext_cnt_d = ext_wrap ? '0 : ext_cnt_q + `ART_DIV_W'(1);

   // Source choice; ext select overrides divide select
   always_comb begin
      case (src_in)
         art_pkg::ART_SRC_SYS_DIV1:  tick_out = 1'b1;
         art_pkg::ART_SRC_SYS_DIV12: tick_out = sys_wrap;
         art_pkg::ART_SRC_EXT_DIV8:  tick_out = ext_wrap;   // RULE_04
         default:                    tick_out = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Prescaler counters
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sys_cnt_q <= '0;
      end else begin
         sys_cnt_q <= sys_cnt_d;
      end
   end

   // Oscillator sampled into system domain; ext must be below half system_clock
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_s1_q  <= 1'b0;
         ext_s2_q  <= 1'b0;
         ext_s3_q  <= 1'b0;
         ext_cnt_q <= '0;
      end else begin
         ext_s1_q <= ext_osc_in;
         ext_s2_q <= ext_s1_q;   // RULE_15
         ext_s3_q <= ext_s2_q;
         if (ext_rise) begin
            ext_cnt_q <= ext_cnt_d;   // RULE_06
         end
      end
   end
endmodule

// ---- logic/art_timer.sv ----
// Auto-reload 16-bit timer with special function register access
// Operation
// RULE_01: 16-bit up-counter visible as low and high count bytes.
// RULE_02: Always auto-reload from low and high reload bytes; no other mode.
// RULE_03: No counter mode; never counts edges of an external pin.
// RULE_04: External select set: clock is oscillator over 8, divide select ignored.
// RULE_05: External select clear: system clock, over 12 when divide bit is 0.
// RULE_06: Timer may count on precise external source apart from system clock.
// RULE_07: Overflow flag set by hardware on rollover from FFFF to 0000.
// RULE_08: Interrupt request raised while flag set and interrupt enabled.
// RULE_09: Flag never cleared by hardware; software writes zero to clear.
// RULE_10: Control bits 6 to 3 read zero, writes ignored.
// RULE_11: Run control bit 2 enables the timer at 1, stops at 0.
// RULE_12: Overflow pulse offered as ADC start and SMBus timing source.
// RULE_13: On overflow count loads reload value, then keeps counting up.
// RULE_14: Stopped timer holds count; byte writes land without advance.
// RULE_15: External clock domain crossed safely into system-clock logic.
`timescale 1ns/1ps
`include "art_cfg.svh"
module art_timer (
   input  wire logic             clk_sys_in,
   input  wire logic             rst_n_in,
   input  wire logic [7:0]       sfr_addr_in,
   input  wire logic             sfr_wr_in,
   input  wire logic             sfr_rd_in,
   input  wire art_pkg::art_byte_t sfr_wdata_in,
   output art_pkg::art_byte_t    sfr_rdata_out,
   output logic                  sfr_hit_out,
   input  wire logic             ext_osc_in,
   input  wire logic             irq_enable_in,
   output logic                  irq_out,
   output logic                  overflow_pulse_out,
   output logic                  adc_start_out,
   output logic                  smbus_tick_out
);
   art_pkg::art_byte_t  ctrl_q;
   art_pkg::art_byte_t  ctrl_d;
   art_pkg::art_count_t count_q;
   art_pkg::art_count_t count_d;
   art_pkg::art_count_t reload_q;
   art_pkg::art_count_t reload_d;
   logic                ovf_pulse_q;
   art_pkg::art_src_t   src_sel;
   art_pkg::art_byte_t  rdata_d;
   wire                 tick;
   wire                 run_control;
   wire                 advance;
   wire                 rollover;
   wire                 wr_ctrl;
   wire                 wr_rl_lo;
   wire                 wr_rl_hi;
   wire                 wr_cnt_lo;
   wire                 wr_cnt_hi;
   wire                 hit;
   wire                 sel_ctrl;
   wire                 sel_rl_lo;
   wire                 sel_rl_hi;
   wire                 sel_cnt_lo;
   wire                 sel_cnt_hi;
   wire                 set_flag;
   wire                 clr_flag;
   wire                 flag_next;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode
   assign sel_ctrl   = (sfr_addr_in == `ART_ADDR_CONTROL);
   assign sel_rl_lo  = (sfr_addr_in == `ART_ADDR_RELOAD_LO);
   assign sel_rl_hi  = (sfr_addr_in == `ART_ADDR_RELOAD_HI);
   assign sel_cnt_lo = (sfr_addr_in == `ART_ADDR_COUNT_LO);
   assign sel_cnt_hi = (sfr_addr_in == `ART_ADDR_COUNT_HI);
   assign wr_ctrl   = sfr_wr_in && sel_ctrl;
   assign wr_rl_lo  = sfr_wr_in && sel_rl_lo;
   assign wr_rl_hi  = sfr_wr_in && sel_rl_hi;
   assign wr_cnt_lo = sfr_wr_in && sel_cnt_lo;
   assign wr_cnt_hi = sfr_wr_in && sel_cnt_hi;
   assign hit       = (sfr_addr_in >= `ART_ADDR_CONTROL) &&
                      (sfr_addr_in <= `ART_ADDR_COUNT_HI);
   assign sfr_hit_out = hit;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock source selection from control bits
   assign run_control = ctrl_q[`ART_BIT_RUN];
   // External select checked first so the divide bit is ignored under it
   assign src_sel = ctrl_q[`ART_BIT_EXT_SEL] ? art_pkg::ART_SRC_EXT_DIV8 :      // RULE_04
                    (ctrl_q[`ART_BIT_DIV_SEL] ? art_pkg::ART_SRC_SYS_DIV1 :     // RULE_05
                     art_pkg::ART_SRC_SYS_DIV12);

   // System clock and external oscillator sources only; no pin edge input exists
   art_tick_gen u_tick (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .src_in     (src_sel),
      .ext_osc_in (ext_osc_in),
      .tick_out   (tick)          // RULE_03
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Count path; a software count byte write in the same cycle wins over the advance for that byte only
   assign advance  = run_control && tick;               // RULE_11
   assign rollover = advance && (count_q == 16'hFFFF);  // RULE_07
   always_comb begin
      count_d = count_q;
      if (rollover) begin
         count_d = reload_q;                            // RULE_02 RULE_13
      end else if (advance) begin
         count_d = count_q + 16'h0001;                  // RULE_01
      end
      if (wr_cnt_lo) begin
         count_d[7:0] = sfr_wdata_in;                   // RULE_14
      end
      if (wr_cnt_hi) begin
         count_d[15:8] = sfr_wdata_in;                  // RULE_14
      end
   end

   // Reload bytes
   always_comb begin
      reload_d = reload_q;
      if (wr_rl_lo) begin
         reload_d[7:0] = sfr_wdata_in;
      end
      if (wr_rl_hi) begin
         reload_d[15:8] = sfr_wdata_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control register; hardware set beats a software clear in the same cycle
   assign set_flag  = rollover;                                  // RULE_07
   assign clr_flag  = wr_ctrl && !sfr_wdata_in[`ART_BIT_OVERFLOW]; // RULE_09
   assign flag_next = set_flag ? 1'b1 :
                      (clr_flag ? 1'b0 :
                       (wr_ctrl | ctrl_q[`ART_BIT_OVERFLOW]));
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = sfr_wdata_in & `ART_CTRL_WMASK;       // RULE_10
      end
      ctrl_d[`ART_BIT_OVERFLOW] = flag_next;            // RULE_09
   end

   // Read mux; unused control bits always zero
   assign rdata_d = sel_ctrl   ? (ctrl_q & `ART_CTRL_WMASK) :   // RULE_10
                    sel_rl_lo  ? reload_q[7:0] :
                    sel_rl_hi  ? reload_q[15:8] :
                    sel_cnt_lo ? count_q[7:0] :
                    sel_cnt_hi ? count_q[15:8] :
                    `ART_RESET_BYTE;

   ////////////////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_q   <= `ART_RESET_BYTE;
         count_q  <= '0;
         reload_q <= '0;
      end else begin
         ctrl_q   <= ctrl_d;
         count_q  <= count_d;
         reload_q <= reload_d;
      end
   end

   // Read data and overflow event registered
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sfr_rdata_out <= `ART_RESET_BYTE;
         ovf_pulse_q   <= 1'b0;
      end else begin
         if (sfr_rd_in) begin
            sfr_rdata_out <= rdata_d;
         end
         ovf_pulse_q <= rollover;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event and interrupt outputs; request is a level while flag stays set
   assign irq_out            = irq_enable_in && ctrl_q[`ART_BIT_OVERFLOW];  // RULE_08
   assign overflow_pulse_out = ovf_pulse_q;
   assign adc_start_out      = ovf_pulse_q;   // RULE_12
   assign smbus_tick_out     = ovf_pulse_q;   // RULE_12
endmodule

// ---- verification/art_core_model.sv ----
// Core-side model: register bus cycles and the external oscillator
`timescale 1ns/1ps
module art_core_model (
   input  wire logic               clk_sys_in,
   input  wire art_pkg::art_byte_t sfr_rdata_in,
   output logic [7:0]              sfr_addr_out,
   output logic                    sfr_wr_out,
   output logic                    sfr_rd_out,
   output art_pkg::art_byte_t      sfr_wdata_out,
   output logic                    ext_osc_out
);
   logic [1:0] osc_cnt_q = 2'h0;
   logic       osc_q = 1'b0;
   // One process owns the oscillator level
   assign ext_osc_out = osc_q;
   // Idle bus at time zero
   initial begin
      sfr_addr_out = 8'h00;
      sfr_wr_out = 1'b0;
      sfr_rd_out = 1'b0;
      sfr_wdata_out = 8'h00;
   end
   // Runs free, period of eight system clocks keeps the sampler safe
   always @(posedge clk_sys_in) begin
      osc_cnt_q <= osc_cnt_q + 2'h1;
      if (osc_cnt_q == 2'h3) begin
         osc_q <= ~osc_q;
      end
   end
   // Strobe held through the sampling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      sfr_addr_out <= a;
      sfr_wdata_out <= d;
      sfr_wr_out <= 1'b1;
      @(posedge clk_sys_in);
      sfr_wr_out <= 1'b0;
   endtask
   // Read data lands at the sampling edge, taken once it settles
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      sfr_addr_out <= a;
      sfr_rd_out <= 1'b1;
      @(posedge clk_sys_in);
      sfr_rd_out <= 1'b0;
      #1;
      d = sfr_rdata_in;
   endtask
endmodule

// ---- verification/art_timer_checker.sv ----
// Port assertions for the auto-reload timer
`timescale 1ns/1ps
`include "art_cfg.svh"
module art_timer_checker (
   input wire logic               clk_sys_in,
   input wire logic               rst_n_in,
   input wire logic [7:0]         sfr_addr_in,
   input wire logic               sfr_wr_in,
   input wire logic               sfr_rd_in,
   input wire art_pkg::art_byte_t sfr_wdata_in,
   input wire art_pkg::art_byte_t sfr_rdata_out,
   input wire logic               sfr_hit_out,
   input wire logic               irq_enable_in,
   input wire logic               irq_out,
   input wire logic               overflow_pulse_out,
   input wire logic               adc_start_out,
   input wire logic               smbus_tick_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);
   wire stop_wr = sfr_wr_in && sfr_addr_in == `ART_ADDR_CONTROL && !sfr_wdata_in[`ART_BIT_RUN];
   ////////////////////////////////////////
   // Event fan-out and the request line
   property p_fanout;
      adc_start_out == overflow_pulse_out && smbus_tick_out == overflow_pulse_out;
   endproperty
   a_fanout: assert property (p_fanout) else $error("trigger fan-out differs");
   property p_gate;
      !irq_enable_in |-> !irq_out;
   endproperty
   a_gate: assert property (p_gate) else $error("request while disabled");
   // Write exclusion: a software clear may land with the pulse
   property p_ovf_irq;
      overflow_pulse_out && irq_enable_in && !$past(sfr_wr_in) |-> irq_out;
   endproperty
   a_ovf_irq: assert property (p_ovf_irq) else $error("no request on overflow");
   property p_hold;
      irq_out && !sfr_wr_in |=> irq_out || !irq_enable_in;
   endproperty
   a_hold: assert property (p_hold) else $error("flag dropped by itself");
   property p_cause;
      $rose(irq_out) && $past(irq_enable_in) && !$past(sfr_wr_in) |-> overflow_pulse_out;
   endproperty
   a_cause: assert property (p_cause) else $error("flag rose without rollover");
   ////////////////////////////////////////
   // Register reads and stopping
   property p_unmapped;
      sfr_rd_in && !sfr_hit_out |=> sfr_rdata_out == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_resv;
      sfr_rd_in && sfr_addr_in == `ART_ADDR_CONTROL |=> sfr_rdata_out[6:3] == 4'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits not zero");
   // A rollover on the stop edge itself may still pulse once
   property p_stop;
      stop_wr |=> ##2 !overflow_pulse_out [*4];
   endproperty
   a_stop: assert property (p_stop) else $error("pulse after stop");
   c_pulse: cover property (overflow_pulse_out);
   c_irq: cover property (irq_out && irq_enable_in);
   c_unmapped: cover property (sfr_rd_in && !sfr_hit_out);
endmodule
bind art_timer art_timer_checker chk (.clk_sys_in, .rst_n_in, .sfr_addr_in, .sfr_wr_in,
   .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .sfr_hit_out, .irq_enable_in, .irq_out,
   .overflow_pulse_out, .adc_start_out, .smbus_tick_out);

// ---- verification/auto_reload_timer_rtc_bench.sv ----
// Self-checking bench for the auto-reload timer
`timescale 1ns/1ps
`include "art_cfg.svh"
module auto_reload_timer_rtc_bench;
   logic       clk_sys_in = 1'b0;
   logic       rst_n_in = 1'b0;
   logic       irq_en = 1'b0;
   logic [7:0] addr, wdata, rdata, v;
   logic       wr, rd, osc, hit, irq, pulse;
   logic [7:0] mode [4] = '{8'h06, 8'h04, 8'h05, 8'h07};
   int         per [4] = '{1, `ART_SYSTEM_CLOCK_DIV, 8 * `ART_EXTCLK_DIV, 8 * `ART_EXTCLK_DIV};
   int         err_total = 0;
   int         checks = 0;
   int         cyc = 0;
   int         n;
   always #2 clk_sys_in = ~clk_sys_in;
   art_timer dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sfr_addr_in(addr),
      .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
      .sfr_hit_out(hit), .ext_osc_in(osc), .irq_enable_in(irq_en), .irq_out(irq),
      .overflow_pulse_out(pulse), .adc_start_out(), .smbus_tick_out());
   art_core_model core (.clk_sys_in(clk_sys_in), .sfr_rdata_in(rdata), .sfr_addr_out(addr),
      .sfr_wr_out(wr), .sfr_rd_out(rd), .sfr_wdata_out(wdata), .ext_osc_out(osc));
   ////////////////////////////////////////
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Third gap only: earlier ones may straddle the mode change
   task automatic gap(output int g);
      for (int j = 0; j < 3; j++) begin
         g = 0;
         do begin
            @(posedge clk_sys_in);
            #1;
            g++;
         end while (pulse !== 1'b1 && g < 2000);
      end
   endtask
   // Hang guard
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   ////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      for (int a = 8'h90; a <= 8'h95; a++) begin
         core.rd(a[7:0], v);
         check("reset byte", v, 8'h00);
      end
      check("hit", hit, 1'b1);
      core.wr(8'h96, 8'hFF);
      check("miss", hit, 1'b0);
      core.wr(`ART_ADDR_CONTROL, 8'h78);
      core.rd(`ART_ADDR_CONTROL, v);
      check("ctrl reserved", v, 8'h00);
      core.wr(`ART_ADDR_COUNT_LO, 8'hF6);
      core.wr(`ART_ADDR_COUNT_HI, 8'hFF);
      core.wr(`ART_ADDR_RELOAD_LO, 8'hF6);
      core.wr(`ART_ADDR_RELOAD_HI, 8'hFF);
      repeat (30) @(posedge clk_sys_in);
      core.rd(`ART_ADDR_COUNT_LO, v);
      check("count held", v, 8'hF6);
      core.rd(`ART_ADDR_RELOAD_LO, v);
      check("reload", v, 8'hF6);
      // Ten counts per period in every clock mode
      @(posedge clk_sys_in);
      irq_en <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         core.wr(`ART_ADDR_CONTROL, mode[i]);
         gap(n);
         check("period", 16'(n), 16'(10 * per[i]));
         check("irq", irq, 1'b1);
         core.rd(`ART_ADDR_CONTROL, v);
         check("flag", v, 8'h80 | mode[i]);
      end
      @(posedge clk_sys_in);
      irq_en <= 1'b0;
      core.wr(`ART_ADDR_CONTROL, 8'h80);
      core.wr(`ART_ADDR_COUNT_LO, 8'hFE);
      repeat (50) @(posedge clk_sys_in);
      check("irq masked", irq, 1'b0);
      core.rd(`ART_ADDR_COUNT_LO, v);
      check("stopped count", v, 8'hFE);
      core.rd(`ART_ADDR_CONTROL, v);
      check("flag kept", v, 8'h80);
      core.wr(`ART_ADDR_CONTROL, 8'h00);
      core.rd(`ART_ADDR_CONTROL, v);
      check("flag cleared", v, 8'h00);
      complete_run();
   end
endmodule
